// file: src/scd_pkg.sv
// Shared constants, types and register map for the step/compare debug unit
package scd_pkg;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int ROM_CYCLE_NS  = 1600;
    localparam int ROM_CYCLE_CYC = ROM_CYCLE_NS / CLK_PERIOD_NS;
    localparam int DEBOUNCE_US   = 5000;
    localparam int DEBOUNCE_CYC  = (DEBOUNCE_US * 1000) / CLK_PERIOD_NS;

    // ==========================================================
    // Widths
    localparam int ADDR_W  = 9;
    localparam int INSTR_W = 16;
    localparam int BYTE_W  = 8;
    localparam int AXI_AW  = 8;
    localparam int AXI_DW  = 32;
    localparam int TMR_W   = 16;

    // ==========================================================
    // Register map
    localparam logic [AXI_AW-1:0] OFF_CTRL   = 8'h00;
    localparam logic [AXI_AW-1:0] OFF_STATUS = 8'h04;
    localparam logic [AXI_AW-1:0] OFF_LAMP_A = 8'h08;
    localparam logic [AXI_AW-1:0] OFF_LAMP_B = 8'h0C;
    localparam logic [AXI_AW-1:0] OFF_LAMP_C = 8'h10;
    localparam logic [AXI_AW-1:0] OFF_CYCLES = 8'h14;

    localparam int CTRL_SOFT_STEP_BIT = 0;
    localparam int CTRL_STOP_BIT      = 1;
    localparam int CTRL_CMP_MASK_BIT  = 2;
    localparam int ST_STATE_LSB       = 0;
    localparam int ST_HIT_BIT         = 2;
    localparam int ST_LATE_BIT        = 3;
    localparam int ST_GO_BIT          = 4;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        SCD_IDLE = 2'h0,
        SCD_STEP = 2'h1,
        SCD_RUN  = 2'h3,
        SCD_HALT = 2'h2
    } scd_state_t;

    typedef struct packed {
        logic [BYTE_W-1:0]  acc;
        logic [BYTE_W-1:0]  aux;
        logic [BYTE_W-1:0]  status_reg_zero;
        logic [BYTE_W-1:0]  status_reg_one;
        logic [BYTE_W-1:0]  alu;
        logic [INSTR_W-1:0] rom_word;
        logic [ADDR_W-1:0]  rom_addr;
        logic [BYTE_W-1:0]  ram_out;
        logic [ADDR_W-1:0]  ram_addr;
        logic               host_ready_busy_lamp;
    } scd_view_t;

    typedef struct packed {
        logic               manual_select;
        logic [INSTR_W-1:0] instr_sw;
        logic               compare_up;
        logic               top_match_switch;
        logic [ADDR_W-1:0]  match_sw;
        logic               auto_mode;
    } scd_panel_t;

endpackage : scd_pkg

// file: src/scd_debounce.sv
// Step pushbutton synchroniser, debouncer and press pulse generator
`timescale 1ns/1ps
module scd_debounce #(
    parameter int STABLE_CYC = scd_pkg::DEBOUNCE_CYC
) (
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Button
    input  wire logic button_raw,
    output logic      press
);
    import scd_pkg::*;

    localparam int CW = $clog2(STABLE_CYC + 1);
    localparam logic [CW-1:0] CNT_TOP = CW'(STABLE_CYC);

    logic          sync_a;
    logic          sync_b;
    logic          clean;
    logic [CW-1:0] cnt;
    logic          next_clean;
    logic [CW-1:0] next_cnt;
    logic          next_press;

    // ==========================================================
    // Filter: level must hold for the full window before it counts
    always_comb begin
        next_clean = clean;
        next_cnt   = '0;
        next_press = 1'b0;
        if (sync_b != clean) begin
            next_cnt = cnt + 1'b1;
            if (cnt == CNT_TOP) begin
                next_clean = sync_b;
                next_cnt   = '0;
                next_press = sync_b;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            clean  <= 1'b0;
            cnt    <= '0;
            press  <= 1'b0;
        end else begin
            sync_a <= button_raw;
            sync_b <= sync_a;
            clean  <= next_clean;
            cnt    <= next_cnt;
            press  <= next_press;
        end
    end

endmodule : scd_debounce

// file: src/scd_unit.sv
// Step/compare debug unit: lamps, manual instruction, run control, AXI4-Lite registers
//
// Operation
// - The lamps continuously show the live registers, ALU, ROM word and address, RAM data/address and host line.
// - With manual source selected, the switch word replaces the ROM output toward the processor and on the lamps.
// - Instruction lamps show the switch word only while the source switch is up, else the ROM output.
// - With comparison enabled and the top match switch up, continuous running halts when the ROM address equals the compare switches.
// - The compare switch enables halting when down and disables it entirely when up.
// - The compare halt stops before the instruction at the matching address executes.
// - In single-step mode each press lets exactly one ROM cycle complete, then stops.
// - In continuous mode one press starts continuous cycling until a halt condition occurs.
// - After a compare halt a press resumes execution from the halted address.
// - Continuous mode with manual source executes the switch word repeatedly every cycle.
// - While stepping the ROM address may legitimately stay put on a branch-to-self.
// - One processor cycle, the step unit, lasts 1.6 us at full speed.
//
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module scd_unit #(
    parameter int DEBOUNCE_CYC = scd_pkg::DEBOUNCE_CYC
) (
    // Clock and reset
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    // AXI4-Lite write address
    input  wire logic [scd_pkg::AXI_AW-1:0]  s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [scd_pkg::AXI_DW-1:0]  s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [scd_pkg::AXI_AW-1:0]  s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [scd_pkg::AXI_DW-1:0]       s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    // Processor under test
    input  wire scd_pkg::scd_view_t          dut_view,
    input  wire logic                        cycle_done,
    output logic [scd_pkg::INSTR_W-1:0]      instr_to_dut,
    output logic                             cycle_go,
    // Operator panel
    input  wire scd_pkg::scd_panel_t         panel,
    input  wire logic                        step_button,
    output scd_pkg::scd_view_t               lamps,
    output logic                             halt_lamp
);
    import scd_pkg::*;

    localparam logic [TMR_W-1:0] LATE_LIMIT = TMR_W'(ROM_CYCLE_CYC);

    logic              btn_press;
    scd_state_t        state;
    scd_state_t        next_state;
    logic              next_go;
    logic              hit;
    logic              next_hit;
    logic              late;
    logic              next_late;
    logic              cmp_mask;
    logic              next_cmp_mask;
    logic              soft_step;
    logic              next_soft_step;
    logic              soft_stop;
    logic              next_soft_stop;
    logic [TMR_W-1:0]  tmr;
    logic [TMR_W-1:0]  next_tmr;
    logic [31:0]       cycles;
    logic [31:0]       next_cycles;
    logic              press;
    logic              match;
    logic              set_hit;
    logic              set_late;
    scd_view_t         next_lamps;
    logic [INSTR_W-1:0] next_instr;

    logic               aw_held;
    logic               next_aw_held;
    logic [AXI_AW-1:0]  aw_addr;
    logic [AXI_AW-1:0]  next_aw_addr;
    logic               w_held;
    logic               next_w_held;
    logic [AXI_DW-1:0]  w_data;
    logic [AXI_DW-1:0]  next_w_data;
    logic [3:0]         w_strb;
    logic [3:0]         next_w_strb;
    logic               next_bvalid;
    logic [1:0]         next_bresp;
    logic               next_rvalid;
    logic [1:0]         next_rresp;
    logic [AXI_DW-1:0]  next_rdata;
    logic               do_write;
    logic [AXI_DW-1:0]  status_word;

    // ==========================================================
    // Button conditioning
    scd_debounce #(
        .STABLE_CYC (DEBOUNCE_CYC)
    ) u_debounce (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .button_raw (step_button),
        .press      (btn_press)
    );

    // ==========================================================
    // Run control
    // Address is checked only when a cycle completes, so a press at a
    // matching address always executes it before comparing again
    always_comb begin
        press = btn_press | soft_step;
        match = !panel.compare_up && !cmp_mask
                && ({panel.top_match_switch, panel.match_sw} == {1'b1, dut_view.rom_addr});
        next_state  = state;
        next_go     = cycle_go;
        set_hit     = 1'b0;
        next_cycles = cycles;
        next_tmr    = cycle_go ? tmr + 1'b1 : '0;
        set_late    = cycle_go && !cycle_done && (tmr == LATE_LIMIT);
        if (cycle_go && cycle_done) begin
            next_cycles = cycles + 32'h0000_0001;
            next_tmr    = '0;
        end
        case (state)
            SCD_IDLE, SCD_HALT: begin
                if (press) begin
                    next_go    = 1'b1;
                    next_state = panel.auto_mode ? SCD_RUN : SCD_STEP;
                end
            end
            SCD_STEP: begin
                // Address may not move on a branch-to-self; still one cycle
                if (cycle_done) begin
                    next_go    = 1'b0;
                    next_state = SCD_IDLE;
                end
            end
            SCD_RUN: begin
                if (soft_stop) begin
                    next_go    = 1'b0;
                    next_state = SCD_HALT;
                end else if (cycle_done && match) begin
                    next_go    = 1'b0;
                    next_state = SCD_HALT;
                    set_hit    = 1'b1;
                end
            end
            default: begin
                next_go    = 1'b0;
                next_state = SCD_IDLE;
            end
        endcase
    end

    // ==========================================================
    // Lamps and instruction path
    always_comb begin
        next_lamps = dut_view;
        next_instr = panel.manual_select ? panel.instr_sw : dut_view.rom_word;
        next_lamps.rom_word = next_instr;
    end

    // ==========================================================
    // Register bus
    always_comb begin
        do_write       = aw_held && w_held && !s_axi_bvalid;
        next_aw_held   = aw_held;
        next_aw_addr   = aw_addr;
        next_w_held    = w_held;
        next_w_data    = w_data;
        next_w_strb    = w_strb;
        next_bvalid    = s_axi_bvalid && !s_axi_bready;
        next_bresp     = s_axi_bresp;
        next_rvalid    = s_axi_rvalid && !s_axi_rready;
        next_rresp     = s_axi_rresp;
        next_rdata     = s_axi_rdata;
        next_soft_step = 1'b0;
        next_soft_stop = 1'b0;
        next_cmp_mask  = cmp_mask;
        next_hit       = hit | set_hit;
        next_late      = late | set_late;
        status_word    = '0;
        status_word[ST_STATE_LSB +: 2] = state;
        status_word[ST_HIT_BIT]        = hit;
        status_word[ST_LATE_BIT]       = late;
        status_word[ST_GO_BIT]         = cycle_go;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = RESP_OKAY;
            case (aw_addr)
                OFF_CTRL: begin
                    if (w_strb[0]) begin
                        next_soft_step = w_data[CTRL_SOFT_STEP_BIT];
                        next_soft_stop = w_data[CTRL_STOP_BIT];
                        next_cmp_mask  = w_data[CTRL_CMP_MASK_BIT];
                    end
                end
                OFF_STATUS: begin
                    // Clear loses to a same-cycle set
                    if (w_strb[0]) begin
                        next_hit  = (hit && !w_data[ST_HIT_BIT]) | set_hit;
                        next_late = (late && !w_data[ST_LATE_BIT]) | set_late;
                    end
                end
                OFF_LAMP_A, OFF_LAMP_B, OFF_LAMP_C, OFF_CYCLES: begin
                    next_bresp = RESP_OKAY;
                end
                default: begin
                    next_bresp = RESP_SLVERR;
                end
            endcase
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp  = RESP_OKAY;
            case (s_axi_araddr)
                OFF_CTRL: begin
                    next_rdata = '0;
                    next_rdata[CTRL_CMP_MASK_BIT] = cmp_mask;
                end
                OFF_STATUS: next_rdata = status_word;
                OFF_LAMP_A: next_rdata = {lamps.acc, lamps.aux, lamps.status_reg_zero, lamps.status_reg_one};
                OFF_LAMP_B: next_rdata = {lamps.alu, lamps.ram_out, lamps.rom_word};
                OFF_LAMP_C: next_rdata = {13'h0000, lamps.host_ready_busy_lamp, lamps.ram_addr, lamps.rom_addr};
                OFF_CYCLES: next_rdata = cycles;
                default: begin
                    next_rdata = '0;
                    next_rresp = RESP_SLVERR;
                end
            endcase
        end
    end

    // ==========================================================
    // State registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state         <= SCD_IDLE;
            cycle_go      <= 1'b0;
            hit           <= 1'b0;
            late          <= 1'b0;
            cmp_mask      <= 1'b0;
            soft_step     <= 1'b0;
            soft_stop     <= 1'b0;
            tmr           <= '0;
            cycles        <= '0;
            lamps         <= '0;
            instr_to_dut  <= '0;
            halt_lamp     <= 1'b0;
            aw_held       <= 1'b0;
            aw_addr       <= '0;
            w_held        <= 1'b0;
            w_data        <= '0;
            w_strb        <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= RESP_OKAY;
            s_axi_rdata   <= '0;
        end else begin
            state         <= next_state;
            cycle_go      <= next_go;
            hit           <= next_hit;
            late          <= next_late;
            cmp_mask      <= next_cmp_mask;
            soft_step     <= next_soft_step;
            soft_stop     <= next_soft_stop;
            tmr           <= next_tmr;
            cycles        <= next_cycles;
            lamps         <= next_lamps;
            instr_to_dut  <= next_instr;
            halt_lamp     <= (next_state == SCD_HALT);
            aw_held       <= next_aw_held;
            aw_addr       <= next_aw_addr;
            w_held        <= next_w_held;
            w_data        <= next_w_data;
            w_strb        <= next_w_strb;
            s_axi_awready <= !next_aw_held && !next_bvalid;
            s_axi_wready  <= !next_w_held && !next_bvalid;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
            s_axi_arready <= !next_rvalid;
            s_axi_rvalid  <= next_rvalid;
            s_axi_rresp   <= next_rresp;
            s_axi_rdata   <= next_rdata;
        end
    end

endmodule : scd_unit

// file: verification/scd_unit_chk.sv
// Concurrent assertion checker for the step/compare debug unit
`timescale 1ns/1ps
module scd_unit_chk (
    // Clock and reset
    input wire logic                   aclk,
    input wire logic                   aresetn,
    // Processor side
    input wire scd_pkg::scd_view_t     dut_view,
    input wire logic                   cycle_done,
    input wire logic [scd_pkg::INSTR_W-1:0] instr_to_dut,
    input wire logic                   cycle_go,
    // Operator panel
    input wire scd_pkg::scd_panel_t    panel,
    input wire logic                   step_button,
    input wire scd_pkg::scd_view_t     lamps,
    input wire logic                   halt_lamp
);
    import scd_pkg::*;
    // ========
    // Helper logic
    scd_view_t  prev_view;
    scd_view_t  want;
    scd_panel_t prev_panel;
    logic       hit;
    assign hit = cycle_go && cycle_done && panel.auto_mode && !panel.compare_up
                 && panel.top_match_switch && (panel.match_sw == dut_view.rom_addr);
    // Instruction field is judged by its own assertions
    always_comb begin
        want          = prev_view;
        want.rom_word = lamps.rom_word;
    end
    always_ff @(posedge aclk) begin
        prev_view  <= dut_view;
        prev_panel <= panel;
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ========
    // Assertions
    a_lamps_live: assert property ($past(aresetn) |-> lamps == want)
        else $error("lamps do not follow processor view");
    a_instr_mux: assert property ($past(aresetn) |-> instr_to_dut ==
        (prev_panel.manual_select ? prev_panel.instr_sw : prev_view.rom_word))
        else $error("instruction source mux wrong");
    a_lamp_word: assert property ($past(aresetn) |-> lamps.rom_word ==
        (prev_panel.manual_select ? prev_panel.instr_sw : prev_view.rom_word))
        else $error("instruction lamps show wrong word");
    a_step_once: assert property (cycle_go && cycle_done && !panel.auto_mode |=> !cycle_go)
        else $error("step mode ran past one cycle");
    a_run_on: assert property (cycle_go && cycle_done && panel.auto_mode && !hit |=> cycle_go)
        else $error("continuous run stopped without match");
    a_cmp_halt: assert property (hit |=> !cycle_go && halt_lamp)
        else $error("no halt on address match");
    a_halt_excl: assert property (cycle_go |-> !halt_lamp)
        else $error("halt lamp lit while running");
    a_go_press: assert property ($rose(cycle_go) |-> step_button && $past(step_button, 4))
        else $error("start without a settled press");
    a_halt_cause: assert property ($rose(halt_lamp) |-> $fell(cycle_go))
        else $error("halt lamp without stop");
endmodule : scd_unit_chk

bind scd_unit scd_unit_chk u_chk (.aclk(aclk), .aresetn(aresetn), .dut_view(dut_view),
    .cycle_done(cycle_done), .instr_to_dut(instr_to_dut), .cycle_go(cycle_go), .panel(panel),
    .step_button(step_button), .lamps(lamps), .halt_lamp(halt_lamp));

// file: verification/scd_proc_model.sv
// Behavioural model of the processor board under test
`timescale 1ns/1ps
module scd_proc_model (
    // Clock and reset
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    // From the debug unit and the testbench
    input  wire logic                          cycle_go,
    input  wire logic [scd_pkg::INSTR_W-1:0]   instr_in,
    input  wire logic [31:0]                   lat,
    input  wire logic                          self_loop,
    // Processor state
    output logic [scd_pkg::ADDR_W-1:0]         rom_addr,
    output logic [scd_pkg::INSTR_W-1:0]        rom_word,
    output logic [scd_pkg::INSTR_W-1:0]        exec_word,
    output logic                               cycle_done
);
    import scd_pkg::*;
    int cnt;
    // Word differs per low address byte so a stale mux shows
    assign rom_word = {~rom_addr[7:0], rom_addr[7:0]};
    always @(posedge aclk) begin
        cycle_done <= 1'b0;
        if (!aresetn || !cycle_go) begin
            cnt <= 0;
            if (!aresetn) begin
                rom_addr  <= '0;
                exec_word <= '0;
            end
        end else if (cnt == lat - 1) begin
            cnt        <= 0;
            cycle_done <= 1'b1;
            exec_word  <= instr_in;
            // Branch to self keeps the address
            if (!self_loop) begin
                rom_addr <= rom_addr + 9'h001;
            end
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule : scd_proc_model

// file: verification/tb_step_compare_debug_unit.sv
// Self-checking testbench for the step/compare debug unit
`timescale 1ns/1ps
module tb_step_compare_debug_unit;
    import scd_pkg::*;
    // ========
    // Signals
    logic        aclk = 0;
    logic        aresetn = 0;
    logic [7:0]  awaddr = '0;
    logic [7:0]  araddr = '0;
    logic [31:0] wdata = '0;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid, cycle_done, cycle_go, halt_lamp;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    scd_view_t   view, lamps;
    scd_panel_t  panel = '0;
    logic [57:0] rnd = '0;
    logic        button = 0, self_loop = 0, spin = 0;
    int          lat = 3;
    logic [8:0]  rom_addr;
    logic [15:0] rom_word, instr, exec_word;
    logic [31:0] lfsr = 32'h30B9;
    int          miscompares = 0, tests_run = 0, exp_addr = 0, exp_cyc = 0;
    assign view = {rnd[57:18], rom_word, rom_addr, rnd[17:0]};
    always #5 aclk = ~aclk;
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    always @(posedge aclk) begin
        lfsr <= lfsr_next(lfsr);
        if (spin) begin
            rnd <= {lfsr[25:0], lfsr};
        end
    end
    scd_unit #(.DEBOUNCE_CYC(4)) dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .dut_view(view), .cycle_done(cycle_done), .instr_to_dut(instr), .cycle_go(cycle_go),
        .panel(panel), .step_button(button), .lamps(lamps), .halt_lamp(halt_lamp));
    scd_proc_model u_proc (.aclk(aclk), .aresetn(aresetn), .cycle_go(cycle_go), .instr_in(instr),
        .lat(lat), .self_loop(self_loop), .rom_addr(rom_addr), .rom_word(rom_word),
        .exec_word(exec_word), .cycle_done(cycle_done));
    // ========
    // Tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask : cyc
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (!bvalid);
        bready <= 0;
        chk(bresp, er);
    endtask : axw
    task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
        end while (!rvalid);
        rready <= 0;
        chk(rdata, ed);
        chk(rresp, er);
    endtask : axr
    task automatic press(input int hold);
        @(posedge aclk);
        button <= 1;
        cyc(hold);
        button <= 0;
        cyc(12);
    endtask : press
    task automatic wait_halt;
        while (!halt_lamp) @(posedge aclk);
    endtask : wait_halt
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop
    // ========
    // Scenarios
    initial begin
        #300000;
        miscompares++;
        report_and_stop();
    end
    initial begin
        cyc(6);
        aresetn <= 1;
        spin <= 1;
        cyc(3);
        spin <= 0;
        panel.top_match_switch <= 1;
        cyc(2);
        axr(OFF_LAMP_A, {view.acc, view.aux, view.status_reg_zero, view.status_reg_one}, RESP_OKAY);
        axr(OFF_LAMP_B, {view.alu, view.ram_out, rom_word}, RESP_OKAY);
        axr(OFF_LAMP_C, {13'h0, view.host_ready_busy_lamp, view.ram_addr, rom_addr}, RESP_OKAY);
        axr(8'h40, 32'h0, RESP_SLVERR);
        axw(8'h40, 32'h4, RESP_SLVERR);
        axw(OFF_CTRL, 32'h4, RESP_OKAY);
        axr(OFF_CTRL, 32'h4, RESP_OKAY);
        axw(OFF_CTRL, 32'h0, RESP_OKAY);
        for (int i = 0; i < 3; i++) begin
            press(15);
            exp_addr++;
            exp_cyc++;
            chk(rom_addr, exp_addr);
            chk(cycle_go, 0);
        end
        // Slow cycle sets the late flag
        lat <= 170;
        press(15);
        cyc(200);
        exp_addr++;
        exp_cyc++;
        axr(OFF_STATUS, 32'h8, RESP_OKAY);
        axw(OFF_STATUS, 32'h8, RESP_OKAY);
        axr(OFF_STATUS, 32'h0, RESP_OKAY);
        lat <= 3;
        self_loop <= 1;
        press(15);
        exp_cyc++;
        chk(rom_addr, exp_addr);
        self_loop <= 0;
        // Short bounce must not start anything
        button <= 1;
        cyc(2);
        button <= 0;
        cyc(20);
        chk(cycle_go, 0);
        axr(OFF_CYCLES, exp_cyc, RESP_OKAY);
        panel.auto_mode <= 1;
        panel.match_sw <= 9'(exp_addr + 5);
        spin <= 1;
        press(15);
        wait_halt();
        exp_addr += 5;
        exp_cyc += 5;
        chk(rom_addr, exp_addr);
        axr(OFF_STATUS, 32'h6, RESP_OKAY);
        // Resume runs from the match address around the whole store
        press(15);
        wait_halt();
        exp_cyc += 512;
        chk(rom_addr, exp_addr);
        axr(OFF_CYCLES, exp_cyc, RESP_OKAY);
        panel.compare_up <= 1;
        panel.manual_select <= 1;
        panel.instr_sw <= lfsr[15:0];
        press(15);
        cyc(1700);
        chk(halt_lamp, 0);
        chk(cycle_go, 1);
        chk(exec_word, panel.instr_sw);
        chk(lamps.rom_word, panel.instr_sw);
        panel.manual_select <= 0;
        panel.compare_up <= 0;
        wait_halt();
        chk(rom_addr, panel.match_sw);
        report_and_stop();
    end
endmodule : tb_step_compare_debug_unit
